// File: hrwc_pkg.sv
/*
 * Constants, register map and carrier types for the hibernation
 * RTC wake controller. Assumes a 12-bit AXI4-Lite byte address.
 */
package hrwc_pkg;

    localparam int ADDR_W = 12;

    // Register byte offsets
    localparam logic [11:0] OFF_RTC     = 12'h000;
    localparam logic [11:0] OFF_MATCH0  = 12'h004;
    localparam logic [11:0] OFF_MATCH1  = 12'h008;
    localparam logic [11:0] OFF_TRIM    = 12'h00c;
    localparam logic [11:0] OFF_CTRL    = 12'h010;
    localparam logic [11:0] OFF_RIS     = 12'h014;
    localparam logic [11:0] OFF_IMASK   = 12'h018;
    localparam logic [11:0] OFF_MIS     = 12'h01c;
    localparam logic [11:0] OFF_ICLR    = 12'h020;
    localparam logic [11:0] OFF_STATUS  = 12'h024;
    localparam logic [3:0]  DATA_PAGE   = 4'h1;

    // Reset values
    localparam logic [15:0] TRIM_RST    = 16'h7fff;
    localparam logic [31:0] ZERO32      = 32'h0000_0000;

    // Interrupt flag positions
    localparam int IRQ_PIN_WAKE    = 0;
    localparam int IRQ_BATTERY_LOW = 1;
    localparam int IRQ_MATCH0      = 2;
    localparam int IRQ_MATCH1      = 3;
    localparam int IRQ_N           = 4;

    // Control bit for a hibernation request, write-only pulse
    localparam int CTRL_HIB_REQ = 7;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Control register, bit 6 downward
    typedef struct packed {
        logic battery_sense_abort_sleep;
        logic battery_sense_detect_only;
        logic wake_rtc_en;
        logic wake_pin_en;
        logic timebase_crystal_divided;
        logic rtc_en;
        logic module_active;
    } hrwc_ctrl_type;

    localparam int CTRL_W = $bits(hrwc_ctrl_type);

    // Power state, Gray along awake -> hibernate -> awake
    typedef enum logic [1:0] {
        ST_AWAKE = 2'h0,
        ST_HIB   = 2'h1
    } hrwc_state_type;

endpackage

// File: hrwc_sync_edge.sv
/*
 * Two-flop synchroniser with rising-edge pulse for one pin.
 * Assumes the pin is asynchronous to core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module hrwc_sync_edge (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic arst_n,
    // Pin and results
    input  wire logic pin_in,
    output logic      level,
    output logic      rise
);
    logic meta_ff;
    logic sync_ff;
    logic prev_ff;

    // Only sync_ff reads meta_ff
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= pin_in;
            sync_ff <= meta_ff;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_ff <= 1'b0;
        end else begin
            prev_ff <= sync_ff;
        end
    end

    assign level = sync_ff;
    assign rise  = sync_ff & ~prev_ff;
endmodule
`default_nettype wire

// File: hrwc_hib_ctrl.sv
/*
 * Always-powered hibernation controller: seconds counter with trimmed
 * pre-divider, two match registers, wake logic, battery sense,
 * interrupt status and 64-word retention memory behind AXI4-Lite.
 * Assumes core_clk and arst_n come from the battery domain, so state
 * survives processor power loss; all pins are asynchronous.
 */
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module hrwc_hib_ctrl
    import hrwc_pkg::*;
#(
    parameter int unsigned MEM_WORDS   = 64,
    parameter int unsigned TRIM_PERIOD = 64,
    parameter int unsigned XTAL_DIV    = 128
) (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              arst_n,
    // AXI4-Lite write
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Pins
    input  wire logic              osc_32k_in,
    input  wire logic              xtal_in,
    input  wire logic              wake_pin,
    input  wire logic              battery_low_in,
    output logic                   regulator_en,
    output logic                   irq
);

    localparam int IW = $clog2(MEM_WORDS);
    localparam int XW = $clog2(XTAL_DIV);
    localparam int TW = $clog2(TRIM_PERIOD);

    if (MEM_WORDS < 2 || MEM_WORDS > 64 || (1 << IW) != MEM_WORDS ||
        XTAL_DIV < 2 || TRIM_PERIOD < 2 ||
        (1 << TW) != TRIM_PERIOD) begin : g_chk
        $error("hrwc_hib_ctrl: unsupported parameter value");
    end

    ////////////////////////////////////////////////////////////////////
    // Pins

    logic osc_rise;
    logic xtal_rise;
    logic wake_lvl;
    logic wake_rise;
    logic batt_lvl;

    hrwc_sync_edge u_osc (.core_clk(core_clk), .arst_n(arst_n),
        .pin_in(osc_32k_in), .level(), .rise(osc_rise));
    hrwc_sync_edge u_xtal (.core_clk(core_clk), .arst_n(arst_n),
        .pin_in(xtal_in), .level(), .rise(xtal_rise));
    hrwc_sync_edge u_wake (.core_clk(core_clk), .arst_n(arst_n),
        .pin_in(wake_pin), .level(wake_lvl), .rise(wake_rise));
    hrwc_sync_edge u_batt (.core_clk(core_clk), .arst_n(arst_n),
        .pin_in(battery_low_in), .level(batt_lvl), .rise());

    ////////////////////////////////////////////////////////////////////
    // Register state

    logic [31:0]    rtc_ff;
    logic [31:0]    match0_ff;
    logic [31:0]    match1_ff;
    logic [15:0]    trim_ff;
    hrwc_ctrl_type  ctrl_ff;
    logic [IRQ_N-1:0] ris_ff;
    logic [IRQ_N-1:0] imask_ff;
    logic [31:0]    mem_ff [MEM_WORDS];
    hrwc_state_type state_ff;
    logic           refused_ff;

    ////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave

    logic              aw_full_ff;
    logic              w_full_ff;
    logic [ADDR_W-1:0] awaddr_ff;
    logic [31:0]       wdata_ff;
    logic [3:0]        wstrb_ff;
    logic              bvalid_ff;
    logic [1:0]        bresp_ff;
    logic              rvalid_ff;
    logic [1:0]        rresp_ff;
    logic [31:0]       rdata_ff;
    logic              do_wr;
    logic              do_rd;
    logic              wr_mem;
    logic              wr_hit;
    logic [31:0]       rd_val;
    logic              rd_hit;

    // Holding registers let address and data arrive in either order
    assign s_axi_awready = ~aw_full_ff;
    assign s_axi_wready  = ~w_full_ff;
    assign do_wr = aw_full_ff & w_full_ff & ~bvalid_ff;
    assign s_axi_arready = ~rvalid_ff;
    assign do_rd = s_axi_arvalid & ~rvalid_ff;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            aw_full_ff <= 1'b0;
            w_full_ff  <= 1'b0;
            awaddr_ff  <= '0;
            wdata_ff   <= ZERO32;
            wstrb_ff   <= 4'h0;
        end else begin
            if (s_axi_awvalid && !aw_full_ff) begin
                aw_full_ff <= 1'b1;
                awaddr_ff  <= s_axi_awaddr;
            end else if (do_wr) begin
                aw_full_ff <= 1'b0;
            end
            if (s_axi_wvalid && !w_full_ff) begin
                w_full_ff <= 1'b1;
                wdata_ff  <= s_axi_wdata;
                wstrb_ff  <= s_axi_wstrb;
            end else if (do_wr) begin
                w_full_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= RESP_OKAY;
        end else if (do_wr) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp  = bresp_ff;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic mem_hit(input logic [ADDR_W-1:0] a);
        return a[11:8] == DATA_PAGE && 32'(a[7:2]) < MEM_WORDS;
    endfunction

    logic wr_rtc;
    logic wr_ctrl;
    logic wr_iclr;
    logic hib_req;

    assign wr_mem  = do_wr & mem_hit(awaddr_ff);
    assign wr_rtc  = do_wr & (awaddr_ff == OFF_RTC);
    assign wr_ctrl = do_wr & (awaddr_ff == OFF_CTRL) & wstrb_ff[0];
    assign wr_iclr = do_wr & (awaddr_ff == OFF_ICLR) & wstrb_ff[0];
    assign hib_req = wr_ctrl & wdata_ff[CTRL_HIB_REQ];

    always_comb begin
        case (awaddr_ff)
            OFF_RTC, OFF_MATCH0, OFF_MATCH1, OFF_TRIM, OFF_CTRL,
            OFF_IMASK, OFF_ICLR: wr_hit = 1'b1;
            default:             wr_hit = mem_hit(awaddr_ff);
        endcase
    end

    always_comb begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            OFF_RTC:    rd_val = rtc_ff;
            OFF_MATCH0: rd_val = match0_ff;
            OFF_MATCH1: rd_val = match1_ff;
            OFF_TRIM:   rd_val = {16'h0000, trim_ff};
            OFF_CTRL:   rd_val = 32'(ctrl_ff);
            OFF_RIS:    rd_val = 32'(ris_ff);
            OFF_IMASK:  rd_val = 32'(imask_ff);
            OFF_MIS:    rd_val = 32'(ris_ff & imask_ff);
            OFF_STATUS: rd_val = {30'h0, refused_ff, regulator_en};
            default: begin
                rd_hit = mem_hit(s_axi_araddr);
                rd_val = rd_hit ? mem_ff[s_axi_araddr[2 +: IW]] : ZERO32;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rvalid_ff <= 1'b0;
            rresp_ff  <= RESP_OKAY;
            rdata_ff  <= ZERO32;
        end else if (do_rd) begin
            rvalid_ff <= 1'b1;
            rresp_ff  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            rdata_ff  <= rd_val;
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rresp  = rresp_ff;
    assign s_axi_rdata  = rdata_ff;

    ////////////////////////////////////////////////////////////////////
    // Configuration registers and retention memory

    // No reset: contents outlive processor power, only battery loss
    always_ff @(posedge core_clk) begin
        if (wr_mem) begin
            mem_ff[awaddr_ff[2 +: IW]] <=
                merge(mem_ff[awaddr_ff[2 +: IW]], wdata_ff, wstrb_ff);
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            match0_ff <= ZERO32;
            match1_ff <= ZERO32;
            trim_ff   <= TRIM_RST;
            ctrl_ff   <= '0;
            imask_ff  <= '0;
        end else if (do_wr) begin
            if (awaddr_ff == OFF_MATCH0)
                match0_ff <= merge(match0_ff, wdata_ff, wstrb_ff);
            if (awaddr_ff == OFF_MATCH1)
                match1_ff <= merge(match1_ff, wdata_ff, wstrb_ff);
            if (awaddr_ff == OFF_TRIM)
                trim_ff <= 16'(merge({16'h0000, trim_ff}, wdata_ff,
                                     wstrb_ff));
            if (wr_ctrl)
                ctrl_ff <= hrwc_ctrl_type'(wdata_ff[CTRL_W-1:0]);
            if (awaddr_ff == OFF_IMASK && wstrb_ff[0])
                imask_ff <= wdata_ff[IRQ_N-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Timebase, pre-divider, trim and seconds counter

    logic [XW-1:0] xdiv_ff;
    logic          xdiv_tick;
    logic          tb_tick;
    logic [15:0]   prediv_ff;
    logic [15:0]   trim_act_ff;
    logic [TW-1:0] trim_cnt_ff;
    logic          sec_tick;

    assign xdiv_tick = xtal_rise & (32'(xdiv_ff) == XTAL_DIV - 1);
    assign tb_tick = ctrl_ff.timebase_crystal_divided ? xdiv_tick
                                                      : osc_rise;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            xdiv_ff <= '0;
        end else if (xdiv_tick) begin
            xdiv_ff <= '0;
        end else if (xtal_rise) begin
            xdiv_ff <= xdiv_ff + 1'b1;
        end
    end

    // Period is trim + 1 timebase ticks
    assign sec_tick = tb_tick & ctrl_ff.rtc_en &
                      (prediv_ff >= trim_act_ff);

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            prediv_ff <= 16'h0000;
        end else if (sec_tick) begin
            prediv_ff <= 16'h0000;
        end else if (tb_tick && ctrl_ff.rtc_en) begin
            prediv_ff <= prediv_ff + 1'b1;
        end
    end

    // Trim writes take effect only at the end of every TRIM_PERIOD-th second
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            trim_cnt_ff <= '0;
            trim_act_ff <= TRIM_RST;
        end else if (sec_tick) begin
            trim_cnt_ff <= trim_cnt_ff + 1'b1;
            if (&trim_cnt_ff) begin
                trim_act_ff <= trim_ff;
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rtc_ff <= ZERO32;
        end else if (wr_rtc) begin
            rtc_ff <= merge(rtc_ff, wdata_ff, wstrb_ff);
        end else if (sec_tick) begin
            rtc_ff <= rtc_ff + 32'h0000_0001;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Match events and interrupt flags

    logic eq0_ff;
    logic eq1_ff;
    logic hit0;
    logic hit1;
    logic batt_sense;
    logic [IRQ_N-1:0] flag_set;
    logic [IRQ_N-1:0] flag_clr;

    // Edge of equality, so a held match fires once
    assign hit0 = ctrl_ff.rtc_en & (rtc_ff == match0_ff) & ~eq0_ff;
    assign hit1 = ctrl_ff.rtc_en & (rtc_ff == match1_ff) & ~eq1_ff;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            eq0_ff <= 1'b0;
            eq1_ff <= 1'b0;
        end else begin
            eq0_ff <= rtc_ff == match0_ff;
            eq1_ff <= rtc_ff == match1_ff;
        end
    end

    assign batt_sense = ctrl_ff.battery_sense_detect_only |
                        ctrl_ff.battery_sense_abort_sleep;

    always_comb begin
        flag_set = '0;
        flag_set[IRQ_PIN_WAKE]    = wake_rise;
        flag_set[IRQ_BATTERY_LOW] = batt_sense & batt_lvl;
        flag_set[IRQ_MATCH0]      = hit0;
        flag_set[IRQ_MATCH1]      = hit1;
    end

    assign flag_clr = wr_iclr ? wdata_ff[IRQ_N-1:0] : '0;

    // Set beats a clear in the same cycle
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ris_ff <= '0;
        end else begin
            ris_ff <= (ris_ff & ~flag_clr) | flag_set;
        end
    end

    assign irq = |(ris_ff & imask_ff);

    ////////////////////////////////////////////////////////////////////
    // Hibernation sequencing

    logic abort_now;
    logic wake_go;

    assign abort_now = ctrl_ff.battery_sense_abort_sleep & batt_lvl;
    // Level on the pin so a held wake still ends hibernation
    assign wake_go = (ctrl_ff.wake_pin_en & wake_lvl) |
                     (ctrl_ff.wake_rtc_en & (hit0 | hit1));

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff   <= ST_AWAKE;
            refused_ff <= 1'b0;
        end else begin
            case (state_ff)
                ST_AWAKE: begin
                    if (hib_req) begin
                        refused_ff <= abort_now;
                        if (!abort_now) begin
                            state_ff <= ST_HIB;
                        end
                    end
                end
                ST_HIB: begin
                    if (wake_go) begin
                        state_ff <= ST_AWAKE;
                    end
                end
                default: state_ff <= ST_AWAKE;
            endcase
        end
    end

    assign regulator_en = state_ff == ST_AWAKE;

    ////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    sequence s_enter;
        state_ff == ST_AWAKE && hib_req && !abort_now;
    endsequence

    sequence s_wake;
        !regulator_en && wake_go;
    endsequence

    a_hib_power_down: assert property (
        s_enter |=> !regulator_en && state_ff == ST_HIB)
        else $error("regulator not dropped on request");
    a_wake_power_up: assert property (
        s_wake |=> regulator_en)
        else $error("regulator not restored on wake");
    a_abort_keeps_on: assert property (
        regulator_en && hib_req && abort_now |=> regulator_en && refused_ff)
        else $error("request not refused on low battery");
    a_rtc_step_one: assert property (
        sec_tick && !wr_rtc |=> rtc_ff == $past(rtc_ff) + 32'h1)
        else $error("counter did not step by one");
    a_rtc_frozen_off: assert property (
        !ctrl_ff.rtc_en && !wr_rtc |=> $stable(rtc_ff))
        else $error("counter moved while disabled");
    a_trim_reload: assert property (
        sec_tick && &trim_cnt_ff |=> trim_act_ff == $past(trim_ff))
        else $error("trim not applied at period end");
    a_match_once: assert property (
        hit0 |=> !hit0 [*2])
        else $error("match event repeated");
    a_match1_once: assert property (
        hit1 |=> !hit1 [*2])
        else $error("second match event repeated");
    a_flag_sticky: assert property (
        ris_ff[IRQ_PIN_WAKE] && !flag_clr[IRQ_PIN_WAKE]
        |=> ris_ff[IRQ_PIN_WAKE])
        else $error("flag lost without clear");
    a_batt_flag: assert property (
        batt_sense && batt_lvl |=> ris_ff[IRQ_BATTERY_LOW])
        else $error("low battery flag not set");
    a_irq_masked: assert property (
        ris_ff[IRQ_PIN_WAKE] && imask_ff[IRQ_PIN_WAKE] |-> irq)
        else $error("enabled flag without interrupt");
    a_wr_answer: assert property (
        do_wr |=> s_axi_bvalid)
        else $error("write not answered");

endmodule
`default_nettype wire

// File: hrwc_far_side.sv
/*
 * Far-side pin model: oscillators, wake pin and battery monitor.
 * Assumes bench commands change just after core_clk rises.
 */
`timescale 1ns/1ps
`default_nettype none
module hrwc_far_side (
    // Clock and bench commands
    input  wire logic core_clk,
    input  wire logic wake_cmd,
    input  wire logic batt_cmd,
    // Pins
    output logic      osc_32k_in,
    output logic      xtal_in,
    output logic      wake_pin,
    output logic      battery_low_in
);
    // Free-running, scaled down so runs stay short
    logic [3:0] div_ff = 4'h0;
    always @(posedge core_clk) begin
        div_ff         <= div_ff + 4'h1;
        wake_pin       <= wake_cmd;
        battery_low_in <= batt_cmd;
    end
    assign osc_32k_in = div_ff[3];
    assign xtal_in    = div_ff[1];
endmodule
`default_nettype wire

// File: tb_hibernation_rtc_wake_controller.sv
/*
 * Register-level bench for the hibernation controller.
 * Assumes the far-side model drives all pins of the design.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_hibernation_rtc_wake_controller
    import hrwc_pkg::*;
;
    logic        core_clk = 1'b0;
    logic        arst_n   = 1'b0;
    logic [11:0] awaddr   = 12'h000;
    logic [11:0] araddr   = 12'h000;
    logic [31:0] wdata    = 32'h0;
    logic [3:0]  wstrb    = 4'hf;
    logic        awvalid  = 1'b0;
    logic        wvalid   = 1'b0;
    logic        bready   = 1'b0;
    logic        arvalid  = 1'b0;
    logic        rready   = 1'b0;
    logic        wake_cmd = 1'b0;
    logic        batt_cmd = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        osc, xtal, wpin, blow, reg_en, irq;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    int          fail_count = 0;
    int          checks     = 0;

    always #20 core_clk = ~core_clk;

    hrwc_far_side hrwc_far_side_inst (.core_clk(core_clk),
        .wake_cmd(wake_cmd), .batt_cmd(batt_cmd), .osc_32k_in(osc),
        .xtal_in(xtal), .wake_pin(wpin), .battery_low_in(blow));

    hrwc_hib_ctrl #(.MEM_WORDS(64), .TRIM_PERIOD(4), .XTAL_DIV(2))
    hrwc_hib_ctrl_inst (.core_clk(core_clk), .arst_n(arst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .osc_32k_in(osc), .xtal_in(xtal),
        .wake_pin(wpin), .battery_low_in(blow), .regulator_en(reg_en),
        .irq(irq));

    ////////////////////////////////////////////////////////////////////
    task print_verdict();
        $display("Checks %0d, mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // A hung handshake ends the run instead of stalling it
    task step(inout int n);
        n++;
        if (n > 60) begin
            chk(32'(n), 32'h0);
            print_verdict();
        end
    endtask

    // Ready is sampled mid-cycle, valids drop just after the edge
    task wr(input logic [11:0] a, input logic [31:0] d);
        int n;
        logic ta, tw, got;
        n = 0;
        got = 1'b0;
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!got) begin
            @(negedge core_clk);
            ta  = awvalid && awready;
            tw  = wvalid && wready;
            got = bvalid;
            if (got) chk(32'(bresp), 32'(RESP_OKAY));
            @(posedge core_clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (got) bready <= 1'b0;
            step(n);
        end
        @(posedge core_clk);
    endtask

    task rd(input logic [11:0] a, input logic [31:0] d, logic [1:0] r);
        int n;
        logic ta, got;
        n = 0;
        got = 1'b0;
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        while (!got) begin
            @(negedge core_clk);
            ta  = arvalid && arready;
            got = rvalid;
            if (got) chk(rdata, d);
            if (got) chk(32'(rresp), 32'(r));
            @(posedge core_clk);
            if (ta) arvalid <= 1'b0;
            if (got) rready <= 1'b0;
            step(n);
        end
        @(posedge core_clk);
    endtask

    // Waits for regulator enable (sel 0) or irq (sel 1) to reach v
    task await(input logic sel, input logic v);
        int n;
        n = 0;
        while ((sel ? irq : reg_en) !== v) begin
            @(negedge core_clk);
            step(n);
        end
        chk(32'(sel ? irq : reg_en), 32'(v));
        @(posedge core_clk);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        await(1'b0, 1'b1);
        rd(OFF_TRIM, 32'h7fff, RESP_OKAY);
        rd(OFF_CTRL, ZERO32, RESP_OKAY);
        rd(12'h080, ZERO32, RESP_SLVERR);
        wr(OFF_RTC, 32'h10);
        rd(OFF_RTC, 32'h10, RESP_OKAY);
        wr(OFF_TRIM, 32'h123);
        rd(OFF_TRIM, 32'h123, RESP_OKAY);
        wr(12'h100, 32'hcafe_0001);
        wr(12'h1fc, 32'h5a5a_00ff);
        rd(12'h100, 32'hcafe_0001, RESP_OKAY);
        rd(12'h1fc, 32'h5a5a_00ff, RESP_OKAY);
        wstrb <= 4'h2;
        wr(12'h100, 32'h0000_3300);
        wstrb <= 4'hf;
        rd(12'h100, 32'hcafe_3301, RESP_OKAY);
        $display("Test registers done");
        wake_cmd <= 1'b1;
        repeat (8) @(posedge core_clk);
        wake_cmd <= 1'b0;
        rd(OFF_RIS, 32'h1, RESP_OKAY);
        wr(OFF_IMASK, 32'h1);
        await(1'b1, 1'b1);
        rd(OFF_MIS, 32'h1, RESP_OKAY);
        wr(OFF_ICLR, 32'h1);
        rd(OFF_RIS, ZERO32, RESP_OKAY);
        await(1'b1, 1'b0);
        $display("Test status done");
        batt_cmd <= 1'b1;
        wr(OFF_CTRL, 32'h21);
        rd(OFF_RIS, 32'h2, RESP_OKAY);
        wr(OFF_CTRL, 32'h69);
        wr(OFF_CTRL, 32'he9);
        rd(OFF_STATUS, 32'h3, RESP_OKAY);
        batt_cmd <= 1'b0;
        wr(OFF_CTRL, 32'h09);
        wr(OFF_ICLR, 32'hf);
        $display("Test low battery done");
        wr(OFF_CTRL, 32'h89);
        await(1'b0, 1'b0);
        wake_cmd <= 1'b1;
        await(1'b0, 1'b1);
        wake_cmd <= 1'b0;
        rd(OFF_CTRL, 32'h09, RESP_OKAY);
        rd(OFF_RIS, 32'h1, RESP_OKAY);
        wr(OFF_ICLR, 32'hf);
        $display("Test pin wake done");
        wr(OFF_MATCH1, 32'h20);
        rd(OFF_MATCH1, 32'h20, RESP_OKAY);
        wr(OFF_CTRL, 32'h13);
        wr(OFF_CTRL, 32'h93);
        await(1'b0, 1'b0);
        wake_cmd <= 1'b1;
        repeat (10) @(posedge core_clk);
        wake_cmd <= 1'b0;
        @(negedge core_clk);
        chk(32'(reg_en), 32'h0);
        @(posedge core_clk);
        wr(OFF_RTC, 32'h20);
        await(1'b0, 1'b1);
        rd(OFF_RIS, 32'h9, RESP_OKAY);
        wr(OFF_ICLR, 32'hf);
        rd(OFF_RIS, ZERO32, RESP_OKAY);
        $display("Test match wake done");
        print_verdict();
    end
endmodule
`default_nettype wire
